// [table_image.sv]
// Purpose: Memory image of the compressed lookup table
// Assumes: Word-organised store, little-endian entries
// Notes:   Only word 5 holds data; every other word reads zero
`timescale 1ns/1ps
module table_image (
    input  wire logic [2:0]  idx,
    output logic      [31:0] word
);
    // Word entries 0x100 and 0x300 at byte offsets 0x14 and 0x16
    assign word = (idx == 3'h5) ? 32'h0300_0100 : 32'h0000_0000;
endmodule

// [tbl_interp.sv]
// Purpose: Table lookup and linear interpolate engine behind an AHB-Lite slave
// Assumes: Software loads instruction words, operands and table, then starts
// Notes:   Effective address is resolved by software into the base register
// What this block does
// - Table mode: first word top ten bits 1111100000, extension fields checked.
// - Register mode: first word bits 5-3 zero, extension mode 00, sources given.
// - Table base only from control addressing modes; others refused as illegal.
// - Size field 00 byte, 01 word, 10 long for entries and registers.
// - Fraction and entry number taken from destination at start; result written back.
// - Mode zero selects register interpolation; otherwise second source field is zero.
// - Rounding bit 0 rounds to nearest, 1 returns the unrounded result.
// - Integer byte scaled by size gives offset of entry and the next.
// - Difference times fraction; rounded adds product/256, unrounded adds entry*256.
// - Register mode uses two source registers and only the fraction byte.
// - Unsigned entries range 0..2^n-1, signed ones are two's complement.
// - Unsigned rounding adds one when the scaled fraction is at least half.
// - Rounded result writes only size part of destination, upper bits kept.
// - Unrounded: fraction in bits 7-0, integer above it by size.
// - Unrounded byte and word results sign or zero extended to 32 bits.
// - Low operand half is 8-bit integer above 8-bit fraction.
// - X kept, C cleared, N and Z from result, V on long overflow.
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module tbl_interp
    import tbl_interp_pkg::*;
#(
    parameter int TBL_DEPTH = 512
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);
    localparam int MEM_AW = $clog2(TBL_DEPTH);

    if (TBL_DEPTH < 2 || (1 << MEM_AW) != TBL_DEPTH || TBL_DEPTH * 4 > TBL_WIN_BYTES)
    begin : g_depth_check
        $error("TBL_DEPTH must be a power of two from 2 to 1024");
    end

    function automatic logic ea_control_ok(input logic [2:0] m, input logic [2:0] r);
        return (m == EA_IND) || (m == EA_DISP) || (m == EA_IDX) || (m == EA_EXT && r <= EA_EXT_MAX);
    endfunction

    // Extracts a size-wide entry from a little-endian word and widens it
    function automatic logic signed [33:0] entry_pick(input logic [31:0] w, input logic [1:0] a,
                                                      input logic [1:0] sz, input logic sgn);
        logic [7:0]  b;
        logic [15:0] h;
        b = 8'(w >> {a, 3'b000});
        h = a[1] ? w[31:16] : w[15:0];
        case (sz)
            SZ_BYTE: return {{26{sgn & b[7]}}, b};
            SZ_WORD: return {{18{sgn & h[15]}}, h};
            default: return {{2{sgn & w[31]}}, w};
        endcase
    endfunction

    // Bus and register state
    logic              dp_valid_reg;
    logic              dp_write_reg;
    logic [12:0]       dp_addr_reg;
    logic [31:0]       instr_reg;
    logic [31:0]       base_reg;
    logic [31:0]       base_lat_reg;
    logic [4:0]        ccr_reg;
    logic [31:0]       dreg [8];
    logic              done_reg;
    logic              illegal_reg;
    state_t            state_reg;
    state_t            state_next;
    decoded_t          dec_reg;
    logic [31:0]       opres_reg;
    logic signed [33:0] e0_reg;
    logic signed [33:0] e1_reg;
    logic [31:0]       mem_rd_data;

    // Address phase decode
    wire        ahb_go   = hsel & htrans[1] & hready;
    wire [12:0] ra       = haddr[12:0];
    wire        ra_dreg  = (ra[12:5] == DREG_OFS[12:5]);
    wire [31:0] rd_mux   = (ra == CTRL_OFS)  ? {29'h0, illegal_reg, done_reg, state_reg != ST_IDLE} :
                           (ra == INSTR_OFS) ? instr_reg :
                           (ra == BASE_OFS)  ? base_reg :
                           (ra == CCR_OFS)   ? {27'h0, ccr_reg} :
                           ra_dreg           ? dreg[ra[4:2]] : 32'h0000_0000;

    // Data phase write strobes
    wire dp_wr     = dp_valid_reg & dp_write_reg;
    wire wr_ctrl   = dp_wr & (dp_addr_reg == CTRL_OFS);
    wire wr_instr  = dp_wr & (dp_addr_reg == INSTR_OFS);
    wire wr_base   = dp_wr & (dp_addr_reg == BASE_OFS);
    wire wr_ccr    = dp_wr & (dp_addr_reg == CCR_OFS);
    wire wr_dreg   = dp_wr & (dp_addr_reg[12:5] == DREG_OFS[12:5]);
    wire wr_tbl    = dp_wr & (dp_addr_reg[12] == TBL_OFS[12]);
    wire start     = wr_ctrl & hwdata[CTRL_START] & (state_reg == ST_IDLE);

    // Instruction decode
    wire [15:0] op_w     = instr_reg[31:16];
    wire [15:0] ext_w    = instr_reg[15:0];
    wire [2:0]  ea_mode  = op_w[5:3];
    wire [2:0]  ea_reg   = op_w[2:0];
    wire [1:0]  ext_mode = ext_w[EXT_MODE_LSB +: 2];
    wire [1:0]  ext_size = ext_w[EXT_SIZE_LSB +: 2];
    wire        op_ok    = (op_w[15:OP_PAT_LSB] == OP_PATTERN) & ~ext_w[EXT_ZERO_BIT];
    wire        tbl_ok   = (ext_mode == EXT_MODE_TABLE) & (ext_w[5:0] == 6'h00)
                           & ea_control_ok(ea_mode, ea_reg);
    wire        reg_ok   = (ext_mode == EXT_MODE_REG) & (ea_mode == EA_DREG)
                           & (ext_w[5:3] == 3'h0);
    wire        size_ok  = (ext_size != 2'h3);
    decoded_t   dec_w;
    assign dec_w = '{legal:      op_ok & size_ok & (tbl_ok | reg_ok),
                     table_mode: tbl_ok,
                     is_signed:  ext_w[EXT_SIGNED_BIT],
                     no_round:   ext_w[EXT_ROUND_BIT],
                     size:       ext_size,
                     dst:        ext_w[EXT_DST_LSB +: 3],
                     src_m:      ea_reg,
                     src_n:      ext_w[2:0]};

    // Entry addressing from the integer byte
    wire [7:0]  idx_w    = opres_reg[15:8];
    wire [31:0] addr0    = base_lat_reg + ({24'h0, idx_w} << dec_reg.size);
    wire [31:0] addr1    = addr0 + (32'h1 << dec_reg.size);
    wire        rd_en    = (state_reg == ST_FETCH0) | (state_reg == ST_FETCH1);
    wire [MEM_AW-1:0] rd_addr = (state_reg == ST_FETCH0) ? addr0[MEM_AW+1:2] : addr1[MEM_AW+1:2];

    // Interpolation arithmetic
    wire [7:0]          frac_w   = opres_reg[7:0];
    wire signed [33:0]  diff     = e1_reg - e0_reg;
    wire signed [42:0]  diff_x   = {{9{diff[33]}}, diff};
    wire signed [42:0]  frac_x   = {35'h0, frac_w};
    wire signed [42:0]  prod     = diff_x * frac_x;
    wire signed [42:0]  prod_sh  = prod >>> 8;
    wire signed [42:0]  mag      = prod[42] ? -prod : prod;
    wire signed [42:0]  mag_q    = (mag >>> 8) + $signed({42'h0, mag[7]});
    wire signed [42:0]  q_sym    = prod[42] ? -mag_q : mag_q;
    wire signed [42:0]  q_up     = prod_sh + $signed({42'h0, prod[7]});
    wire signed [42:0]  adj      = dec_reg.is_signed ? q_sym : q_up;
    wire signed [42:0]  e0_x     = {{9{e0_reg[33]}}, e0_reg};
    wire signed [42:0]  rnd_full = e0_x + adj;
    wire signed [42:0]  unr_full = (e0_x <<< 8) + prod;
    wire                ext_bit  = dec_reg.is_signed & unr_full[42];

    // Result placement
    wire [31:0] rnd_res = (dec_reg.size == SZ_BYTE) ? {opres_reg[31:8], rnd_full[7:0]} :
                          (dec_reg.size == SZ_WORD) ? {opres_reg[31:16], rnd_full[15:0]} :
                          rnd_full[31:0];
    wire [31:0] unr_res = (dec_reg.size == SZ_BYTE) ? {{16{ext_bit}}, unr_full[15:0]} :
                          (dec_reg.size == SZ_WORD) ? {{8{ext_bit}}, unr_full[23:0]} :
                          unr_full[31:0];
    wire [31:0] result  = dec_reg.no_round ? unr_res : rnd_res;
    wire        rnd_n   = (dec_reg.size == SZ_BYTE) ? rnd_full[7] :
                          (dec_reg.size == SZ_WORD) ? rnd_full[15] : rnd_full[31];
    wire        rnd_z   = (dec_reg.size == SZ_BYTE) ? (rnd_full[7:0] == 8'h00) :
                          (dec_reg.size == SZ_WORD) ? (rnd_full[15:0] == 16'h0000) :
                          (rnd_full[31:0] == 32'h0000_0000);
    wire        flag_n  = dec_reg.no_round ? unr_res[31] : rnd_n;
    wire        flag_z  = dec_reg.no_round ? (unr_res == 32'h0000_0000) : rnd_z;
    wire        flag_v  = dec_reg.no_round & (dec_reg.size == SZ_LONG)
                          & ~((&unr_full[42:31]) | ~(|unr_full[42:31]));
    wire        calc    = (state_reg == ST_CALC);

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:   if (start && dec_w.legal) state_next = dec_w.table_mode ? ST_FETCH0 : ST_CALC;
            ST_FETCH0: state_next = ST_FETCH1;
            ST_FETCH1: state_next = ST_LAST;
            ST_LAST:   state_next = ST_CALC;
            ST_CALC:   state_next = ST_IDLE;
            default:   state_next = ST_IDLE;
        endcase
    end

    tbl_mem #(
        .DATA_W (32),
        .DEPTH  (TBL_DEPTH)
    ) u_tbl_mem (
        .clk     (hclk),
        .rst_n   (hresetn),
        .ce      (ce),
        .wr_en   (wr_tbl),
        .wr_addr (dp_addr_reg[MEM_AW+1:2]),
        .wr_data (hwdata),
        .rd_en   (rd_en),
        .rd_addr (rd_addr),
        .rd_data (mem_rd_data)
    );

    // Bus slave; zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg  <= '0;
            hrdata       <= WORD_RST;
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
        end
        else if (ce)
        begin
            dp_valid_reg <= ahb_go;
            dp_write_reg <= hwrite;
            dp_addr_reg  <= ra;
            if (ahb_go && !hwrite)
            begin
                hrdata <= rd_mux;
            end
        end
    end

    // Software-visible registers; engine writeback wins a same-cycle clash
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            instr_reg <= WORD_RST;
            base_reg  <= WORD_RST;
            ccr_reg   <= CCR_RST;
            for (int i = 0; i < 8; i++)
            begin
                dreg[i] <= WORD_RST;
            end
        end
        else if (ce)
        begin
            if (wr_instr)
            begin
                instr_reg <= hwdata;
            end
            if (wr_base)
            begin
                base_reg <= hwdata;
            end
            if (calc)
            begin
                ccr_reg <= {ccr_reg[CCR_X], flag_n, flag_z, flag_v, 1'b0};
            end
            else if (wr_ccr)
            begin
                ccr_reg <= hwdata[4:0];
            end
            if (wr_dreg && !(calc && dp_addr_reg[4:2] == dec_reg.dst))
            begin
                dreg[dp_addr_reg[4:2]] <= hwdata;
            end
            if (calc)
            begin
                dreg[dec_reg.dst] <= result;
            end
        end
    end

    // Engine sequencing
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg    <= ST_IDLE;
            dec_reg      <= '0;
            opres_reg    <= WORD_RST;
            base_lat_reg <= WORD_RST;
            e0_reg       <= '0;
            e1_reg       <= '0;
            done_reg     <= 1'b0;
            illegal_reg  <= 1'b0;
        end
        else if (ce)
        begin
            state_reg <= state_next;
            if (start)
            begin
                dec_reg      <= dec_w;
                opres_reg    <= dreg[dec_w.dst];
                base_lat_reg <= base_reg;
                done_reg     <= ~dec_w.legal;
                illegal_reg  <= ~dec_w.legal;
                // Register mode operands come from the pair, integer byte unused
                e0_reg <= entry_pick(dreg[dec_w.src_m], 2'h0, dec_w.size, dec_w.is_signed);
                e1_reg <= entry_pick(dreg[dec_w.src_n], 2'h0, dec_w.size, dec_w.is_signed);
            end
            if (state_reg == ST_FETCH1)
            begin
                e0_reg <= entry_pick(mem_rd_data, addr0[1:0], dec_reg.size, dec_reg.is_signed);
            end
            if (state_reg == ST_LAST)
            begin
                e1_reg <= entry_pick(mem_rd_data, addr1[1:0], dec_reg.size, dec_reg.is_signed);
            end
            if (calc)
            begin
                done_reg <= 1'b1;
            end
        end
    end

    // Part of the written register that Z must reflect
    wire [31:0] wb_word = dreg[dec_reg.dst];
    wire [31:0] wb_mask = dec_reg.no_round ? 32'hFFFF_FFFF : (dec_reg.size == SZ_BYTE) ? 32'h0000_00FF :
                          (dec_reg.size == SZ_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn || !ce);

    a_illegal_refused: assert property (start && !dec_w.legal |=> illegal_reg && state_reg == ST_IDLE)
        else $error("illegal encoding was not refused");
    a_reg_mode_path: assert property (start && dec_w.legal && !dec_w.table_mode
                                      |=> state_reg == ST_CALC ##1 state_reg == ST_IDLE && done_reg)
        else $error("register mode did not finish in two cycles");
    a_ea_restricted: assert property (start && (ext_mode == EXT_MODE_TABLE)
                                      && !ea_control_ok(ea_mode, ea_reg) |=> state_reg == ST_IDLE)
        else $error("non-control addressing mode accepted");
    a_table_sequence: assert property (start && dec_w.legal && dec_w.table_mode |=> state_reg == ST_FETCH0
                                       ##1 state_reg == ST_FETCH1 ##1 state_reg == ST_LAST ##1 calc)
        else $error("table fetch sequence broken");
    a_entry_stride: assert property (state_reg == ST_FETCH1 |->
                                     (addr1 - addr0) == ((dec_reg.size == SZ_BYTE) ? 32'h1 :
                                     (dec_reg.size == SZ_WORD) ? 32'h2 : 32'h4))
        else $error("next entry not one entry further");
    a_round_upper_kept: assert property (calc && !dec_reg.no_round && dec_reg.size == SZ_BYTE
                                         |=> dreg[dec_reg.dst][31:8] == $past(opres_reg[31:8]))
        else $error("rounded byte result disturbed upper bits");
    a_unsigned_zero_ext: assert property (calc && dec_reg.no_round && !dec_reg.is_signed
                                          && dec_reg.size == SZ_BYTE |=> dreg[dec_reg.dst][31:16] == 16'h0000)
        else $error("unsigned unrounded byte not zero extended");
    a_frac_zero_low: assert property (calc && dec_reg.no_round && frac_w == 8'h00
                                      |=> dreg[dec_reg.dst][7:0] == 8'h00)
        else $error("fraction byte wrong for zero fraction");
    a_frac_zero_round: assert property (calc && !dec_reg.no_round && frac_w == 8'h00 && dec_reg.size == SZ_LONG
                                        |=> dreg[dec_reg.dst] == $past(e0_reg[31:0]))
        else $error("zero fraction did not return the entry");
    a_flags_cx: assert property (calc |=> !ccr_reg[CCR_C] && ccr_reg[CCR_X] == $past(ccr_reg[CCR_X])
                                 && ccr_reg[CCR_Z] == ((wb_word & wb_mask) == 32'h0000_0000))
        else $error("condition codes wrong after result");

    c_table_done:  cover property (state_reg == ST_LAST ##1 calc ##1 done_reg);
    c_reg_done:    cover property (start && dec_w.legal && !dec_w.table_mode ##2 done_reg);
    c_illegal:     cover property (start && !dec_w.legal);
    c_overflow:    cover property (calc && flag_v);
endmodule

// [tbl_interp_pkg.sv]
// Purpose: Shared constants and types for the table lookup and interpolate engine
// Assumes: 32-bit AHB-Lite register bus, word-aligned registers
// Notes:   Offsets are byte addresses within the slave's window
package tbl_interp_pkg;

    // Register map (byte offsets, low 13 address bits decoded)
    localparam int          DEC_W      = 13;
    localparam logic [12:0] CTRL_OFS   = 13'h0000;
    localparam logic [12:0] INSTR_OFS  = 13'h0004;
    localparam logic [12:0] BASE_OFS   = 13'h0008;
    localparam logic [12:0] CCR_OFS    = 13'h000C;
    localparam logic [12:0] DREG_OFS   = 13'h0020;
    localparam logic [12:0] TBL_OFS    = 13'h1000;
    localparam int          TBL_WIN_BYTES = 4096;

    // Control and status bits
    localparam int CTRL_START   = 0;
    localparam int CTRL_BUSY    = 0;
    localparam int CTRL_DONE    = 1;
    localparam int CTRL_ILLEGAL = 2;

    // Condition code bit positions
    localparam int CCR_C = 0;
    localparam int CCR_V = 1;
    localparam int CCR_Z = 2;
    localparam int CCR_N = 3;
    localparam int CCR_X = 4;

    // Reset values
    localparam logic [4:0]  CCR_RST   = 5'h00;
    localparam logic [31:0] WORD_RST  = 32'h0000_0000;

    // Instruction encoding
    localparam logic [9:0] OP_PATTERN     = 10'h3E0;
    localparam int         OP_PAT_LSB     = 6;
    localparam int         EXT_ZERO_BIT   = 15;
    localparam int         EXT_DST_LSB    = 12;
    localparam int         EXT_SIGNED_BIT = 11;
    localparam int         EXT_ROUND_BIT  = 10;
    localparam int         EXT_MODE_LSB   = 8;
    localparam int         EXT_SIZE_LSB   = 6;
    localparam logic [1:0] EXT_MODE_TABLE = 2'h1;
    localparam logic [1:0] EXT_MODE_REG   = 2'h0;

    // Operand sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;

    // Addressing modes; EA_DREG is for register mode, the others are control modes
    localparam logic [2:0] EA_DREG    = 3'h0;
    localparam logic [2:0] EA_IND     = 3'h2;
    localparam logic [2:0] EA_DISP    = 3'h5;
    localparam logic [2:0] EA_IDX     = 3'h6;
    localparam logic [2:0] EA_EXT     = 3'h7;
    localparam logic [2:0] EA_EXT_MAX = 3'h3;

    typedef struct packed {
        logic       legal;
        logic       table_mode;
        logic       is_signed;
        logic       no_round;
        logic [1:0] size;
        logic [2:0] dst;
        logic [2:0] src_m;
        logic [2:0] src_n;
    } decoded_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_FETCH0 = 3'b001,
        ST_FETCH1 = 3'b010,
        ST_LAST   = 3'b011,
        ST_CALC   = 3'b100
    } state_t;

endpackage

// [tbl_mem.sv]
// Purpose: Word memory holding the lookup table
// Assumes: One write port, one read port, same clock
// Notes:   Read data appear one enabled edge after the address
`timescale 1ns/1ps
module tbl_mem #(
    parameter int DATA_W = 32,
    parameter int DEPTH  = 512
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [DATA_W-1:0]        wr_data,
    input  wire logic                     rd_en,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [DATA_W-1:0]        rd_data
);
    logic [DATA_W-1:0] mem_array [DEPTH];

    // Array kept reset-free so it maps onto RAM
    always_ff @(posedge clk)
    begin
        if (ce && wr_en)
        begin
            mem_array[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data <= '0;
        end
        else if (ce && rd_en)
        begin
            rd_data <= mem_array[rd_addr];
        end
    end
endmodule

// [testbench.sv]
// Purpose: Self-checking bench for the lookup and interpolate engine
// Assumes: Zero-wait AHB-Lite slave, master waits on hready anyway
// Notes:   Expected results worked by hand from the interpolation formula
`timescale 1ns/1ps
module testbench
    import tbl_interp_pkg::*;
;
    logic        hclk = 0, hresetn = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, got, word;
    logic [1:0]  htrans = 0;
    logic [2:0]  idx = 0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp;
    int          errors = 0, n_compared = 0, cycles = 0;

    always #50 hclk = ~hclk;

    tbl_interp dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));
    table_image img (.idx(idx), .word(word));

    task automatic wt;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic xfer(input logic [12:0] a, input logic w, input logic [31:0] d);
        htrans <= 2'h2;
        haddr  <= {19'h0, a};
        hwrite <= w;
        wt;
        htrans <= 2'h0;
        hwdata <= d;
        wt;
        got = hrdata;
    endtask

    task automatic chk(input string name, input logic [12:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        n_compared++;
        if (hresp !== 1'b0)
        begin
            errors++;
            $display("BAD hresp expected 0 seen %b", hresp);
        end
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Polls done for at most 20 reads; a stuck engine then fails the check that follows
    task automatic run(input logic [31:0] instr);
        xfer(INSTR_OFS, 1'b1, instr);
        xfer(CTRL_OFS, 1'b1, 32'h1);
        got = 32'h0;
        for (int i = 0; i < 20 && got[CTRL_DONE] !== 1'b1; i++)
            xfer(CTRL_OFS, 1'b0, 32'h0);
    endtask

    // Register mode: sources in data registers 2 and 3
    task automatic rcase(input logic [31:0] instr, input logic [12:0] opr, input logic [31:0] v,
                         input logic [31:0] m, input logic [31:0] n, input logic [31:0] exp);
        xfer(DREG_OFS + 13'h8, 1'b1, m);
        xfer(DREG_OFS + 13'hC, 1'b1, n);
        xfer(opr, 1'b1, v);
        run(instr);
        chk("result", opr, exp);
    endtask

    task automatic conclude;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            conclude;
        end
    end

    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        chk("ccr", CCR_OFS, {27'h0, CCR_RST});
        xfer(CCR_OFS, 1'b1, 32'h11);
        rcase(32'hF802_0003, DREG_OFS, 32'hAABB_1280, 32'h10, 32'h20, 32'hAABB_1218);
        rcase(32'hF802_4C43, DREG_OFS + 13'h10, 32'h1234_5640, 32'hFFFF, 32'h1, 32'hFFFF_FF80);
        chk("ccr", CCR_OFS, 32'h18);
        rcase(32'hF802_5083, DREG_OFS + 13'h14, 32'h80, 32'h0, 32'h3, 32'h2);
        // Signed halfway below zero rounds away from zero
        rcase(32'hF802_7803, DREG_OFS + 13'h1C, 32'h1122_3350, 32'h10, 32'h08, 32'h1122_330D);
        rcase(32'hF802_1C83, DREG_OFS + 13'h4, 32'h0, 32'h0080_0000, 32'h0080_0000, 32'h8000_0000);
        chk("ccr", CCR_OFS, 32'h1A);
        for (int i = 0; i < 8; i++)
        begin
            // Let the image settle before its word is sampled
            idx <= 3'(i);
            @(posedge hclk);
            xfer(TBL_OFS + 13'(4 * i), 1'b1, word);
        end
        xfer(BASE_OFS, 1'b1, 32'h10);
        xfer(DREG_OFS + 13'h18, 1'b1, 32'hFFFF_0201);
        run(32'hF810_6540);
        chk("table", DREG_OFS + 13'h18, 32'h0001_0200);
        run(32'hF818_6540);
        chk("illegal", CTRL_OFS, 32'h6);
        chk("unmapped", 13'h0010, 32'h0);
        chk("window", TBL_OFS, 32'h0);
        conclude;
    end
endmodule
